// >>> hw/kps_pkg.sv
package kps_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_MHZ           = 100;
   localparam int unsigned OSC_KHZ           = 4000;                        // Nominal oscillator, 4.0 MHz
   localparam int unsigned OSC_DIV           = (CLK_MHZ * 1000) / OSC_KHZ;  // System clocks per osc tick
   localparam int unsigned KEY_FILT_TICKS    = 400;                         // Key filter, in osc ticks
   localparam int unsigned POR_PULSE_TICKS   = 16;                          // Reset pulse length, osc ticks
   localparam int unsigned SPI_GAP_NS        = 1000;                        // Least gap between transfers
   localparam int unsigned SPI_GAP_CYC       = (SPI_GAP_NS + 9) / 10;

   // ----------------------------------------
   // Control register layout, reset values and status key bit
   // ----------------------------------------
   localparam int unsigned CTRL1_HOLD_BIT    = 0;
   localparam int unsigned CTRL1_SDDIS_BIT   = 1;
   localparam logic [7:0]  CTRL1_RESET       = 8'h00;
   localparam logic [7:0]  OUT_CTRL_RESET    = 8'h00;
   localparam int unsigned STAT_KEY_BIT      = 0;

   // ----------------------------------------
   // States
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_SLEEP,
      ST_NORMAL,
      ST_PREP_SHDN
   } kps_state_e;

   // Supply enables travel together
   typedef struct packed {
      logic pre_reg;
      logic mcu_sup;
      logic sens_sup;
   } kps_supply_s;

endpackage : kps_pkg

// >>> hw/kps_key_filter.sv
`timescale 1ns/100ps
module kps_key_filter #(
   parameter int unsigned FILT_TICKS = kps_pkg::KEY_FILT_TICKS
) (
   input  wire logic CLK,          // System clock
   input  wire logic RESETN,       // Async reset, active low
   input  wire logic osc_tick,     // One pulse per oscillator cycle
   input  wire logic key_raw,      // Raw key level
   output logic      key_filt      // Qualified key level
);

   // ----------------------------------------
   // Synchroniser and qualification counter
   // ----------------------------------------
   logic        sync1_r, sync2_r;
   logic        filt_r, filt_nxt;
   logic [15:0] cnt_r, cnt_nxt;

   // Any return to agreement restarts the count, so short spikes never qualify
   always_comb begin
      filt_nxt = filt_r;
      cnt_nxt  = cnt_r;
      if (sync2_r == filt_r) begin
         cnt_nxt = 16'h0000;
      end else if (osc_tick) begin
         if (cnt_r >= 16'(FILT_TICKS - 1)) begin
            filt_nxt = sync2_r;
            cnt_nxt  = 16'h0000;
         end else begin
            cnt_nxt = cnt_r + 16'h0001;
         end
      end
   end

   // Two-stage synchroniser, then registered filter state
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         filt_r  <= 1'b0;
         cnt_r   <= 16'h0000;
      end else begin
         sync1_r <= key_raw;
         sync2_r <= sync1_r;
         filt_r  <= filt_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   assign key_filt = filt_r;

endmodule : kps_key_filter

// >>> hw/kps_power_ctrl.sv
`timescale 1ns/100ps
// Overview of operation
// - Key held high past filter time in sleep gives reset and normal state
// - Qualification timer stops short key pulses from causing a reset
// - Once enabled, outputs follow initial control contents or parallel input pins
// - Rising key turns on pre-regulator, MCU supply and sensor supply
// - Key level readable by host as one status bit
// - Key state output follows key input by default
// - Key low with hold bit set keeps supplies on; key high stays normal
// - Timers derive from a nominal 4.0 MHz internal oscillator
// - Key low and hold bit low: sleep, every supply and driver output off
// - Rising key in sleep wakes, starts pre-regulator, issues reset
// - Prepare-to-shutdown turns off outputs only, except relay 2 if shutdown-disable
module kps_power_ctrl #(
   parameter int unsigned FILT_TICKS = kps_pkg::KEY_FILT_TICKS,
   parameter int unsigned POR_TICKS  = kps_pkg::POR_PULSE_TICKS,
   parameter int unsigned N_OUT      = 8
) (
   input  wire logic             CLK,             // 100 MHz system clock
   input  wire logic             RESETN,          // Async reset, active low
   input  wire logic             IGNITION_KEY_INPUT, // Key level, asynchronous
   input  wire logic             CTRL_WR,         // Host write strobe for control regs
   input  wire logic [7:0]       CTRL1_WDATA,     // Control register 1 write data
   input  wire logic [N_OUT-1:0] OUT_CTRL_WDATA,  // Output on/off register write data
   input  wire logic             KEY_STATE_HSD,   // Key state output in driver mode
   input  wire logic             KEY_STATE_HSD_ON,// Driver-mode level
   input  wire logic [N_OUT-1:0] PAR_IN,          // Parallel input pins
   input  wire logic [N_OUT-1:0] PAR_SEL,         // 1: output from parallel pin
   output logic                  POR_OUT,         // Generated reset, active high
   output kps_pkg::kps_supply_s  SUPPLY_EN,       // Supply enables
   output logic [N_OUT-1:0]      OUT_EN,          // Driver enables
   output logic                  KEY_STATE_OUTPUT,    // Key mirror
   output logic                  KEY_STATE_OUTPUT_ALT,// Inverted key mirror
   output logic [7:0]            STATUS,          // Status byte, key at bit 0
   output logic [7:0]            CTRL1,           // Control register 1 readback
   output kps_pkg::kps_state_e   STATE            // Operating state
);

   localparam int unsigned RELAY2 = 3;            // Second relay output index

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // Supplies run in every state but sleep
   function automatic logic is_awake(kps_pkg::kps_state_e st);
      return (st != kps_pkg::ST_SLEEP);
   endfunction : is_awake

   // ----------------------------------------
   // Oscillator tick from system clock
   // ----------------------------------------
   logic [7:0] div_r, div_nxt;
   logic       osc_tick;

   // Time base stands in for the internal oscillator
   always_comb begin
      osc_tick = (div_r == 8'(kps_pkg::OSC_DIV - 1));
      div_nxt  = osc_tick ? 8'h00 : div_r + 8'h01;
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         div_r <= 8'h00;
      end else begin
         div_r <= div_nxt;
      end
   end

   // ----------------------------------------
   // Key filter
   // ----------------------------------------
   logic key_filt;

   kps_key_filter #(
      .FILT_TICKS (FILT_TICKS)
   ) u_filt (
      .CLK      (CLK),
      .RESETN   (RESETN),
      .osc_tick (osc_tick),
      .key_raw  (IGNITION_KEY_INPUT),
      .key_filt (key_filt)
   );

   // ----------------------------------------
   // State machine and reset pulse
   // ----------------------------------------
   kps_pkg::kps_state_e state_r, state_nxt;
   logic [7:0]          por_cnt_r, por_cnt_nxt;
   logic                por_r, por_nxt;
   logic [7:0]          ctrl1_r, ctrl1_nxt;
   logic [N_OUT-1:0]    outc_r, outc_nxt;
   logic                key_d_r;
   logic                hold;

   assign hold = ctrl1_r[kps_pkg::CTRL1_HOLD_BIT];

   // Key rise in sleep wakes and resets; hold decides sleep vs prepare
   always_comb begin
      state_nxt   = state_r;
      por_nxt     = por_r;
      por_cnt_nxt = por_cnt_r;
      case (state_r)
         kps_pkg::ST_SLEEP: begin
            if (key_filt && !key_d_r) begin
               state_nxt   = kps_pkg::ST_NORMAL;
               por_nxt     = 1'b1;
               por_cnt_nxt = 8'h00;
            end
         end
         kps_pkg::ST_NORMAL: begin
            if (!key_filt) begin
               state_nxt = hold ? kps_pkg::ST_PREP_SHDN : kps_pkg::ST_SLEEP;
            end
         end
         kps_pkg::ST_PREP_SHDN: begin
            if (key_filt) begin
               state_nxt = kps_pkg::ST_NORMAL;
            end else if (!hold) begin
               state_nxt = kps_pkg::ST_SLEEP;
            end
         end
         default: begin
            state_nxt = kps_pkg::ST_SLEEP;
         end
      endcase
      // Stretch reset over a fixed number of oscillator ticks
      if (por_r && osc_tick) begin
         if (por_cnt_r >= 8'(POR_TICKS - 1)) begin
            por_nxt = 1'b0;
         end else begin
            por_cnt_nxt = por_cnt_r + 8'h01;
         end
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   // Reset pulse wins over host writes so defaults always land
   always_comb begin
      ctrl1_nxt = ctrl1_r;
      outc_nxt  = outc_r;
      if (por_r) begin
         ctrl1_nxt = kps_pkg::CTRL1_RESET;
         outc_nxt  = N_OUT'(kps_pkg::OUT_CTRL_RESET);
      end else if (CTRL_WR) begin
         ctrl1_nxt = CTRL1_WDATA;
         outc_nxt  = OUT_CTRL_WDATA;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_r   <= kps_pkg::ST_SLEEP;
         por_r     <= 1'b0;
         por_cnt_r <= 8'h00;
         ctrl1_r   <= kps_pkg::CTRL1_RESET;
         outc_r    <= N_OUT'(kps_pkg::OUT_CTRL_RESET);
         key_d_r   <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         por_r     <= por_nxt;
         por_cnt_r <= por_cnt_nxt;
         ctrl1_r   <= ctrl1_nxt;
         outc_r    <= outc_nxt;
         key_d_r   <= key_filt;
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   logic [N_OUT-1:0]    out_nxt, out_r;
   kps_pkg::kps_supply_s sup_nxt, sup_r;
   logic                ks_nxt, ks_r;

   // Outputs only run in normal; relay 2 may survive prepare-to-shutdown
   always_comb begin
      for (int i = 0; i < N_OUT; i++) begin
         out_nxt[i] = PAR_SEL[i] ? PAR_IN[i] : outc_r[i];
         if (state_r == kps_pkg::ST_PREP_SHDN) begin
            if (!(i == RELAY2 && ctrl1_r[kps_pkg::CTRL1_SDDIS_BIT])) begin
               out_nxt[i] = 1'b0;
            end
         end else if (state_r != kps_pkg::ST_NORMAL || por_r) begin
            out_nxt[i] = 1'b0;
         end
      end
      sup_nxt.pre_reg  = is_awake(state_r);
      sup_nxt.mcu_sup  = is_awake(state_r);
      sup_nxt.sens_sup = is_awake(state_r);
      ks_nxt = KEY_STATE_HSD ? KEY_STATE_HSD_ON : key_filt;
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         out_r <= '0;
         sup_r <= '0;
         ks_r  <= 1'b0;
      end else begin
         out_r <= out_nxt;
         sup_r <= sup_nxt;
         ks_r  <= ks_nxt;
      end
   end

   // Status: key level at its bit, rest zero
   always_comb begin
      STATUS = 8'h00;
      STATUS[kps_pkg::STAT_KEY_BIT] = key_d_r;
   end

   assign POR_OUT              = por_r;
   assign SUPPLY_EN            = sup_r;
   assign OUT_EN               = out_r;
   assign KEY_STATE_OUTPUT     = ks_r;
   assign KEY_STATE_OUTPUT_ALT = ~ks_r;
   assign CTRL1                = ctrl1_r;
   assign STATE                = state_r;

endmodule : kps_power_ctrl

// >>> tb/kps_power_ctrl_properties.sv
`timescale 1ns/100ps
module kps_power_ctrl_checker #(
   parameter int unsigned N_OUT     = 8,
   parameter int unsigned POR_TICKS = kps_pkg::POR_PULSE_TICKS
) (
   input wire logic                 CLK,                  // System clock
   input wire logic                 RESETN,               // Async reset
   input wire logic                 IGNITION_KEY_INPUT,   // Key level
   input wire logic                 KEY_STATE_HSD,        // Driver mode
   input wire logic                 POR_OUT,              // Generated reset
   input wire kps_pkg::kps_supply_s SUPPLY_EN,            // Supplies
   input wire logic [N_OUT-1:0]     OUT_EN,               // Drivers
   input wire logic                 KEY_STATE_OUTPUT,     // Key mirror
   input wire logic                 KEY_STATE_OUTPUT_ALT, // Inverted mirror
   input wire logic [7:0]           STATUS,               // Status byte
   input wire kps_pkg::kps_state_e  STATE                 // State
);
   // ----------------------------------------
   // Port relations
   // ----------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);

   // Reset pulse length in clocks; the tick phase at wake sets the spread
   localparam int unsigned POR_MIN = (POR_TICKS - 1) * kps_pkg::OSC_DIV + 1;
   localparam int unsigned POR_MAX = POR_TICKS * kps_pkg::OSC_DIV;
   logic [15:0] por_len_r;

   // Counts clocks with the reset pulse high
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         por_len_r <= 16'h0000;
      end else begin
         por_len_r <= POR_OUT ? por_len_r + 16'h0001 : 16'h0000;
      end
   end

   a_alt_inverted: assert property (KEY_STATE_OUTPUT_ALT == !KEY_STATE_OUTPUT)
      else $error("alt key output not inverted");
   // Wake needs reset high and the key already high 50 clocks earlier
   a_wake_por: assert property ($past(STATE) == kps_pkg::ST_SLEEP && STATE == kps_pkg::ST_NORMAL
      |-> POR_OUT && $past(IGNITION_KEY_INPUT, 50)) else $error("wake without reset or qualified key");
   a_por_length: assert property ($fell(POR_OUT) |-> por_len_r >= 16'(POR_MIN) && por_len_r <= 16'(POR_MAX))
      else $error("reset pulse length wrong");
   a_por_bounded: assert property (POR_OUT |-> por_len_r < 16'(POR_MAX))
      else $error("reset pulse too long");
   a_por_outs_off: assert property (POR_OUT |-> OUT_EN == '0)
      else $error("drivers on during reset");
   a_sleep_all_off: assert property (STATE == kps_pkg::ST_SLEEP |=> SUPPLY_EN == 3'h0 && OUT_EN == '0)
      else $error("sleep left something on");
   a_supply_on: assert property (STATE != kps_pkg::ST_SLEEP |=> SUPPLY_EN == 3'h7)
      else $error("supplies off while awake");
   a_prep_outs_off: assert property (STATE == kps_pkg::ST_PREP_SHDN |=> OUT_EN[N_OUT-1:4] == '0
      && OUT_EN[2:0] == 3'h0) else $error("drivers on in shutdown prep");
   a_status_key: assert property (!KEY_STATE_HSD && !$past(KEY_STATE_HSD)
      |-> STATUS == {7'h00, KEY_STATE_OUTPUT}) else $error("status key bit wrong");
endmodule : kps_power_ctrl_checker

bind kps_power_ctrl kps_power_ctrl_checker #(.N_OUT(N_OUT), .POR_TICKS(POR_TICKS)) u_chk (.CLK, .RESETN, .IGNITION_KEY_INPUT,
   .KEY_STATE_HSD, .POR_OUT, .SUPPLY_EN, .OUT_EN, .KEY_STATE_OUTPUT, .KEY_STATE_OUTPUT_ALT, .STATUS, .STATE);

// >>> tb/kps_key_switch_model.sv
`timescale 1ns/100ps
module kps_key_switch_model (
   input  wire logic CLK,     // System clock
   input  wire logic turn_on, // Key turned on
   input  wire logic bounce,  // Contact chatter
   output logic      key      // Key pin level
);
   logic key_r = 1'b0;
   // Chatter flips every cycle, far too short to qualify; off is pulled low
   always_ff @(posedge CLK) begin
      key_r <= bounce ? !key_r : turn_on;
   end
   assign key = key_r;
endmodule : kps_key_switch_model

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin num_errors++; \
   $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module tb_top;
   logic                clk = 1'b0, resetn = 1'b0, ctrl_wr = 1'b0, turn_on = 1'b0, bounce = 1'b0;
   logic [7:0]          c1_wd = 8'h00, oc_wd = 8'h00, par_in = 8'h00, par_sel = 8'h00, status, ctrl1, out_en;
   logic                key, por, kso, kso_alt;
   logic                hsd = 1'b0, hsd_on = 1'b0;
   kps_pkg::kps_supply_s supply;
   kps_pkg::kps_state_e  state;
   int                  num_errors = 0, n_checks = 0, cycles = 0;

   // ----------------------------------------
   // Clock, parts, watchdog
   // ----------------------------------------
   always #5 clk = ~clk;
   kps_key_switch_model u_key (.CLK(clk), .turn_on(turn_on), .bounce(bounce), .key(key));
   kps_power_ctrl #(.FILT_TICKS(4), .POR_TICKS(2), .N_OUT(8)) dut (.CLK(clk), .RESETN(resetn),
      .IGNITION_KEY_INPUT(key), .CTRL_WR(ctrl_wr), .CTRL1_WDATA(c1_wd), .OUT_CTRL_WDATA(oc_wd),
      .KEY_STATE_HSD(hsd), .KEY_STATE_HSD_ON(hsd_on), .PAR_IN(par_in), .PAR_SEL(par_sel), .POR_OUT(por),
      .SUPPLY_EN(supply), .OUT_EN(out_en), .KEY_STATE_OUTPUT(kso), .KEY_STATE_OUTPUT_ALT(kso_alt),
      .STATUS(status), .CTRL1(ctrl1), .STATE(state));
   // Cut a hang well past the expected run of under two thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   task automatic step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic wait_state(kps_pkg::kps_state_e st);
      for (int i = 0; i < 400; i++) begin
         @(posedge clk);
         #1;
         if (state === st) break;
      end
      `CHK("state", st, state)
   endtask : wait_state
   task automatic write_ctrl(logic [7:0] c1, logic [7:0] oc);
      @(posedge clk);
      c1_wd <= c1;
      oc_wd <= oc;
      ctrl_wr <= 1'b1;
      @(posedge clk);
      ctrl_wr <= 1'b0;
      step(kps_pkg::SPI_GAP_CYC);
   endtask : write_ctrl

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_glitch;
      @(posedge clk);
      bounce <= 1'b1;
      step(300);
      @(posedge clk);
      bounce <= 1'b0;
      step(150);
      `CHK("state", kps_pkg::ST_SLEEP, state)
      `CHK("supply", 3'h0, supply)
      $display("glitch test done");
   endtask : t_glitch
   task automatic t_wake;
      @(posedge clk);
      turn_on <= 1'b1;
      par_sel <= 8'h00;
      wait_state(kps_pkg::ST_NORMAL);
      `CHK("por", 1'b1, por)
      write_ctrl(8'h03, 8'hFF); // Falls inside the reset pulse, so refused
      `CHK("por", 1'b0, por)
      `CHK("supply", 3'h7, supply)
      `CHK("key_out", 2'b10, {kso, kso_alt})
      `CHK("status", 8'h01, status)
      `CHK("ctrl1", 8'h00, ctrl1)
      `CHK("out_en", 8'h00, out_en)
      @(posedge clk);
      par_in <= 8'hF0;
      par_sel <= 8'h30;
      write_ctrl(8'h00, 8'h0F);
      `CHK("out_en", 8'h3F, out_en)
      $display("wake test done");
   endtask : t_wake
   task automatic t_prep;
      write_ctrl(8'h03, 8'hFF);
      @(posedge clk);
      turn_on <= 1'b0;
      wait_state(kps_pkg::ST_PREP_SHDN);
      step(2);
      `CHK("supply", 3'h7, supply)
      `CHK("out_en", 8'h08, out_en)
      `CHK("key_out", 1'b0, kso)
      `CHK("status", 8'h00, status)
      @(posedge clk);
      turn_on <= 1'b1;
      wait_state(kps_pkg::ST_NORMAL);
      `CHK("por", 1'b0, por)
      @(posedge clk);
      turn_on <= 1'b0;
      wait_state(kps_pkg::ST_PREP_SHDN);
      write_ctrl(8'h01, 8'hFF);
      `CHK("out_en", 8'h00, out_en)
      // Shutdown-disable left set so the next wake must clear it
      write_ctrl(8'h02, 8'hFF);
      wait_state(kps_pkg::ST_SLEEP);
      step(2);
      `CHK("all_off", 11'h000, {supply, out_en})
      $display("shutdown test done");
   endtask : t_prep
   // Driver mode overrides the mirror; status still shows the key
   task automatic t_hsd;
      @(posedge clk);
      hsd    <= 1'b1;
      hsd_on <= 1'b0;
      step(2);
      `CHK("key_out", 2'b01, {kso, kso_alt})
      `CHK("status", 8'h01, status)
      @(posedge clk);
      hsd_on <= 1'b1;
      step(2);
      `CHK("key_out", 2'b10, {kso, kso_alt})
      @(posedge clk);
      hsd    <= 1'b0;
      hsd_on <= 1'b0;
      step(2);
      `CHK("key_out", 2'b10, {kso, kso_alt})
      $display("driver mode test done");
   endtask : t_hsd

   // Second wake proves control defaults return after each reset
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      t_glitch();
      t_wake();
      t_prep();
      t_wake();
      t_hsd();
      give_verdict();
   end
endmodule : tb_top
